// ---- verilog/cssq_sequencer.sv ----
// cell scan command sequencer: command start/end timing, chain forwarding, voltage scan
`include "cssq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cssq_sequencer #(
  parameter int DW           = 14,
  parameter int TW           = 16,
  parameter int T_CELL_FIRST = `CSSQ_US_CYC(`CSSQ_T_CELL_FIRST_US),
  parameter int T_CELL_LAST  = `CSSQ_US_CYC(`CSSQ_T_CELL_LAST_US),
  parameter int T_VBAT       = `CSSQ_US_CYC(`CSSQ_T_VBAT_US),
  parameter int T_TEMP       = `CSSQ_US_CYC(`CSSQ_T_TEMP_US),
  parameter int T_VSS        = `CSSQ_US_CYC(`CSSQ_T_VSS_US),
  parameter int T_VBTST      = `CSSQ_US_CYC(`CSSQ_T_VBTST_US),
  parameter int T_LOAD       = `CSSQ_US_CYC(`CSSQ_T_LOAD_US)
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  dsy_clk,
  input  wire cssq_pkg::cssq_role_type dev_role,
  input  wire logic [3:0]            stack_size,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_mosi,
  input  wire logic                  dsy_rx,
  input  wire logic                  dsy_frame,
  output logic                       dsy_tx,
  output logic                       dsy_tx_oe,
  output logic                       scan_start,
  output logic                       cmd_end,
  output logic                       scan_busy,
  output logic                       scan_done,
  output logic                       fwd_overrun,
  output logic [3:0]                 adc_chan,
  output logic                       adc_hold,
  output logic                       adc_start,
  input  wire logic                  adc_done,
  input  wire logic [DW-1:0]         adc_data,
  input  wire logic [DW-1:0]         cal_offset,
  input  wire logic [3:0]            rd_addr,
  output logic      [DW-1:0]         rd_data
);

  // =====================================================================
  // elaboration checks
  if (!(T_CELL_FIRST < T_CELL_LAST && T_CELL_LAST < T_VBAT && T_VBAT < T_TEMP &&
        T_TEMP < T_VSS && T_VSS < T_VBTST && T_VBTST < T_LOAD &&
        T_LOAD < (1 << TW) - 1 && DW >= 2)) begin : g_chk
    $error("cssq_sequencer: milestones out of order or timer too narrow");
  end

  // =====================================================================
  // schedule decoding
  // issue time of scan item k; cells are spread evenly between first and last
  function automatic logic [TW-1:0] item_time(input logic [3:0] k);
    int t;
    t = T_LOAD;
    if (k < 4'(`CSSQ_CELLS)) begin
      t = T_CELL_FIRST + ((T_CELL_LAST - T_CELL_FIRST) * int'(k)) / (`CSSQ_CELLS - 1);
    end else begin
      case (k)
        4'hC:    t = T_VBAT;
        4'hD:    t = T_TEMP;
        4'hE:    t = T_VSS;
        default: t = T_VBTST;
      endcase
    end
    return TW'(t);
  endfunction

  // result slot and converter channel of item k: cell n sits at n-1
  function automatic logic [3:0] item_slot(input logic [3:0] k);
    if (k < 4'(`CSSQ_CELLS)) begin
      return 4'(`CSSQ_CELLS - 1) - k;
    end
    return k;
  endfunction

  // =====================================================================
  // reference clock domain state
  typedef struct packed {
    logic                    sclk_s1, sclk_s2, sclk_s3;
    logic                    cs_s1, cs_s2, cs_s3;
    logic                    mosi_s1, mosi_s2;
    logic [3:0]              bit_cnt;
    logic [7:0]              shift;
    logic                    first_byte;
    logic [8:0]              hold;
    logic                    pend;
    logic [8:0]              xfer;
    logic                    req_tg;
    logic                    ack_s1, ack_s2;
    logic                    str_s1, str_s2, str_s3;
    logic                    end_s1, end_s2, end_s3;
    cssq_pkg::cssq_scan_type st;
    logic [TW-1:0]           timer;
    logic [3:0]              item;
    logic                    lphase;
    logic                    start_p, end_p, done_p, overrun, conv_p, hold_en;
    logic [3:0]              chan;
  } cssq_ref_type;

  // chain clock domain state
  typedef struct packed {
    logic                    req_s1, req_s2;
    logic [1:0]              role_s1, role_s2;
    logic [3:0]              n_s1, n_s2;
    logic [7:0]              tx_sh;
    logic [4:0]              tx_cnt;
    logic                    tx_pad;
    logic                    ack_tg, end_tg, start_tg;
    logic [3:0]              rx_cnt;
    logic [7:0]              rx_sh;
    logic                    rx_done;
    logic                    tx_r, oe_r;
  } cssq_dsy_type;

  cssq_ref_type r_r;
  cssq_ref_type r_nxt;
  cssq_dsy_type d_r;
  cssq_dsy_type d_nxt;

  logic            mem_we;
  logic [4:0]      mem_waddr;
  logic [DW-1:0]   mem_wdata;
  logic [DW-1:0]   mem_a;

  // =====================================================================
  // reference domain: SPI decode, forwarding launch, scan sequencer
  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic byte_end;
    logic launch;
    logic go;
    sclk_rise = r_r.sclk_s2 & ~r_r.sclk_s3;
    sclk_fall = ~r_r.sclk_s2 & r_r.sclk_s3;
    cs_rise   = ~r_r.cs_s2 & r_r.cs_s3;
    byte_end  = 1'b0;
    launch    = 1'b0;
    go        = 1'b0;
    r_nxt         = r_r;
    r_nxt.start_p = 1'b0;
    r_nxt.end_p   = 1'b0;
    r_nxt.done_p  = 1'b0;
    r_nxt.conv_p  = 1'b0;
    // pins pass two flops before any logic reads them
    r_nxt.sclk_s1 = spi_sclk;
    r_nxt.sclk_s2 = r_r.sclk_s1;
    r_nxt.sclk_s3 = r_r.sclk_s2;
    r_nxt.cs_s1   = ~spi_cs_n;  // kept as select: reset value is idle, no false edge
    r_nxt.cs_s2   = r_r.cs_s1;
    r_nxt.cs_s3   = r_r.cs_s2;
    r_nxt.mosi_s1 = spi_mosi;
    r_nxt.mosi_s2 = r_r.mosi_s1;
    r_nxt.ack_s1  = d_r.ack_tg;
    r_nxt.ack_s2  = r_r.ack_s1;
    r_nxt.str_s1  = d_r.start_tg;
    r_nxt.str_s2  = r_r.str_s1;
    r_nxt.str_s3  = r_r.str_s2;
    r_nxt.end_s1  = d_r.end_tg;
    r_nxt.end_s2  = r_r.end_s1;
    r_nxt.end_s3  = r_r.end_s2;
    // bits shift in on rising sclk; a byte closes on the falling edge after bit 8
    if (!r_r.cs_s2) begin
      r_nxt.bit_cnt    = 4'h0;
      r_nxt.first_byte = 1'b1;
    end else begin
      if (sclk_rise) begin
        r_nxt.shift   = {r_r.shift[6:0], r_r.mosi_s2};
        r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
      end
      if (sclk_fall && r_r.bit_cnt == `CSSQ_BYTE_BITS) begin
        r_nxt.bit_cnt    = 4'h0;
        r_nxt.first_byte = 1'b0;
        byte_end         = 1'b1;
      end
    end
    // hand each byte to the chain
    if (r_r.pend && r_r.req_tg == r_r.ack_s2) begin
      r_nxt.xfer   = r_r.hold;
      r_nxt.req_tg = ~r_r.req_tg;
      r_nxt.pend   = 1'b0;
      launch       = 1'b1;
    end
    if (r_r.cs_s2 & ~r_r.cs_s3) begin
      r_nxt.overrun = 1'b0;
    end
    // on frame end queue the padding byte plus extra clocks
    if (dev_role == cssq_pkg::CSSQ_MASTER && (byte_end || cs_rise)) begin
      // single slot only; a byte arriving before the chain took the last overwrites it, and the older byte is lost
      if (r_r.pend && !launch) begin
        r_nxt.overrun = 1'b1;
      end
      r_nxt.hold = byte_end ? {1'b0, r_r.shift} : 9'h100;
      r_nxt.pend = 1'b1;
    end
    // start at the closing falling edge of a scan command byte
    if (byte_end && r_r.first_byte && r_r.shift == `CSSQ_OP_SCAN_VOLT &&
        dev_role != cssq_pkg::CSSQ_CHAIN) begin
      go = 1'b1;
      // stand-alone ends its command with the start
      if (dev_role == cssq_pkg::CSSQ_SOLO && r_r.st == cssq_pkg::CSSQ_IDLE) begin
        r_nxt.end_p = 1'b1;
      end
    end
    // chained device starts from its own chain-side decode
    if (dev_role == cssq_pkg::CSSQ_CHAIN && (r_r.str_s2 ^ r_r.str_s3)) begin
      go = 1'b1;
    end
    // master reports command end once padding has left the chain port
    if (dev_role == cssq_pkg::CSSQ_MASTER && (r_r.end_s2 ^ r_r.end_s3)) begin
      r_nxt.end_p = 1'b1;
    end
    // timer saturates so a stalled converter cannot wrap the schedule
    if (r_r.st != cssq_pkg::CSSQ_IDLE && r_r.timer != '1) begin
      r_nxt.timer = r_r.timer + 1'b1;
    end
    case (r_r.st)
      cssq_pkg::CSSQ_IDLE: begin
        if (go) begin
          r_nxt.st      = cssq_pkg::CSSQ_WAIT;
          r_nxt.timer   = '0;
          r_nxt.item    = 4'h0;
          r_nxt.start_p = 1'b1;
        end
      end
      // sample each item at its scheduled time
      cssq_pkg::CSSQ_WAIT: begin
        if (r_r.timer >= item_time(r_r.item)) begin
          r_nxt.conv_p  = 1'b1;
          r_nxt.hold_en = 1'b1;
          r_nxt.chan    = item_slot(r_r.item);
          r_nxt.st      = cssq_pkg::CSSQ_CONV;
        end
      end
      cssq_pkg::CSSQ_CONV: begin
        if (adc_done) begin
          r_nxt.hold_en = 1'b0;
          // items advance cells, pack, temp, tests
          if (r_r.item == `CSSQ_LAST_ITEM) begin
            r_nxt.item   = 4'h0;
            r_nxt.lphase = 1'b0;
            r_nxt.st     = cssq_pkg::CSSQ_CAL_RD;
          end else begin
            r_nxt.item = r_r.item + 4'h1;
            r_nxt.st   = cssq_pkg::CSSQ_WAIT;
          end
        end
      end
      cssq_pkg::CSSQ_CAL_RD: begin
        r_nxt.st = cssq_pkg::CSSQ_CAL_WR;
      end
      // calibrate in place, then copy to readable bank
      cssq_pkg::CSSQ_CAL_WR: begin
        if (r_r.item == `CSSQ_LAST_ITEM) begin
          r_nxt.item = 4'h0;
          if (!r_r.lphase) begin
            r_nxt.st = cssq_pkg::CSSQ_LOAD_WAIT;
          end else begin
            r_nxt.st     = cssq_pkg::CSSQ_IDLE;
            r_nxt.done_p = 1'b1;
          end
        end else begin
          r_nxt.item = r_r.item + 4'h1;
          r_nxt.st   = cssq_pkg::CSSQ_CAL_RD;
        end
      end
      // register load waits for its milestone
      cssq_pkg::CSSQ_LOAD_WAIT: begin
        if (r_r.timer >= TW'(T_LOAD)) begin
          r_nxt.lphase = 1'b1;
          r_nxt.st     = cssq_pkg::CSSQ_CAL_RD;
        end
      end
      default: begin
        r_nxt.st = cssq_pkg::CSSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // result memory write port: raw samples, calibrated values, loaded copy
  always_comb begin
    mem_we    = (r_r.st == cssq_pkg::CSSQ_CONV && adc_done) ||
                (r_r.st == cssq_pkg::CSSQ_CAL_WR);
    mem_waddr = {r_r.lphase, r_r.item};
    mem_wdata = r_r.lphase ? mem_a : DW'(mem_a + cal_offset);
    if (r_r.st == cssq_pkg::CSSQ_CONV) begin
      mem_waddr = {1'b0, item_slot(r_r.item)};
      mem_wdata = adc_data;
    end
  end

  cssq_result_mem #(
    .DW (DW),
    .AW (5)
  ) u_mem (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .wr_en     (mem_we),
    .wr_addr   (mem_waddr),
    .wr_data   (mem_wdata),
    .rd_a_addr ({1'b0, r_r.item}),
    .rd_a_data (mem_a),
    .rd_b_addr ({1'b1, rd_addr}),
    .rd_b_data (rd_data)
  );

  // =====================================================================
  // chain domain: relay, command byte decode, master transmit
  always_comb begin
    logic [7:0] rx_word;
    logic [4:0] ext;
    rx_word = {d_r.rx_sh[6:0], dsy_rx};
    ext     = (d_r.n_s2 > 4'h2) ? {1'b0, d_r.n_s2 - 4'h2} : 5'h00;
    d_nxt         = d_r;
    d_nxt.req_s1  = r_r.req_tg;
    d_nxt.req_s2  = d_r.req_s1;
    d_nxt.role_s1 = dev_role;
    d_nxt.role_s2 = d_r.role_s1;
    d_nxt.n_s1    = stack_size;
    d_nxt.n_s2    = d_r.n_s1;
    d_nxt.tx_r    = 1'b0;
    d_nxt.oe_r    = 1'b0;
    case (d_r.role_s2)
      // relay adds exactly one chain clock
      2'(cssq_pkg::CSSQ_CHAIN): begin
        d_nxt.tx_r = dsy_rx;
        d_nxt.oe_r = dsy_frame;
        if (dsy_frame) begin
          d_nxt.rx_sh = rx_word;
          if (!d_r.rx_done) begin
            d_nxt.rx_cnt = d_r.rx_cnt + 4'h1;
            // command byte closes on its last chain clock
            if (d_r.rx_cnt == `CSSQ_BYTE_LAST) begin
              d_nxt.rx_done = 1'b1;
              if (rx_word == `CSSQ_OP_SCAN_VOLT) begin
                d_nxt.start_tg = ~d_r.start_tg;
              end
            end
          end
        end else begin
          d_nxt.rx_cnt  = 4'h0;
          d_nxt.rx_done = 1'b0;
        end
      end
      2'(cssq_pkg::CSSQ_MASTER): begin
        if (d_r.tx_cnt != 5'h00) begin
          d_nxt.tx_r   = d_r.tx_sh[7];
          d_nxt.oe_r   = 1'b1;
          d_nxt.tx_sh  = {d_r.tx_sh[6:0], 1'b0};
          d_nxt.tx_cnt = d_r.tx_cnt - 5'h01;
          if (d_r.tx_cnt == 5'h01 && d_r.tx_pad) begin
            d_nxt.end_tg = ~d_r.end_tg;
          end
        end else if (d_r.req_s2 != d_r.ack_tg) begin
          // xfer is held still by the handshake while it is copied here
          d_nxt.tx_sh  = r_r.xfer[7:0];
          d_nxt.tx_pad = r_r.xfer[8];
          // zero byte then N-2 clocks reach the chain end
          d_nxt.tx_cnt = r_r.xfer[8] ? 5'h08 + ext : 5'h08;
          d_nxt.ack_tg = ~d_r.ack_tg;
        end
      end
      default: begin
        d_nxt.tx_cnt = 5'h00;
      end
    endcase
  end

  always_ff @(posedge dsy_clk or posedge sys_rst) begin
    if (sys_rst) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign dsy_tx      = d_r.tx_r;
  assign dsy_tx_oe   = d_r.oe_r;
  assign scan_start  = r_r.start_p;
  assign cmd_end     = r_r.end_p;
  assign scan_busy   = (r_r.st != cssq_pkg::CSSQ_IDLE);
  assign scan_done   = r_r.done_p;
  assign fwd_overrun = r_r.overrun;
  assign adc_chan    = r_r.chan;
  assign adc_hold    = r_r.hold_en;
  assign adc_start   = r_r.conv_p;

endmodule

`default_nettype wire

// ---- verilog/cssq_regs.svh ----
// timing figures and command constants of the cell scan command sequencer
`ifndef CSSQ_REGS_SVH
`define CSSQ_REGS_SVH

// reference clock rate in MHz; converts microseconds to ref_clk cycles
`define CSSQ_REF_MHZ        20
`define CSSQ_US_CYC(us)     ((us) * `CSSQ_REF_MHZ)

// scan milestones after start of scan, typical, in microseconds
`define CSSQ_T_CELL_FIRST_US 17
`define CSSQ_T_CELL_LAST_US  251
`define CSSQ_T_VBAT_US       304
`define CSSQ_T_TEMP_US       423
`define CSSQ_T_VSS_US        550
`define CSSQ_T_VBTST_US      726
`define CSSQ_T_LOAD_US       766

// scan items: 12 cells, pack, temperature, two connection tests
`define CSSQ_CELLS          12
`define CSSQ_LAST_ITEM      4'hF
`define CSSQ_BYTE_BITS      4'h8
`define CSSQ_BYTE_LAST      4'h7

// command byte that starts a voltage scan
`define CSSQ_OP_SCAN_VOLT   8'h30

`endif

// ---- verilog/cssq_pkg.sv ----
// shared types of the cell scan command sequencer
package cssq_pkg;

  // position of this device in the stack
  typedef enum logic [1:0] {
    CSSQ_SOLO,
    CSSQ_MASTER,
    CSSQ_CHAIN
  } cssq_role_type;

  // voltage scan sequencer states
  typedef enum logic [2:0] {
    CSSQ_IDLE,
    CSSQ_WAIT,
    CSSQ_CONV,
    CSSQ_CAL_RD,
    CSSQ_CAL_WR,
    CSSQ_LOAD_WAIT
  } cssq_scan_type;

endpackage

// ---- verilog/cssq_result_mem.sv ----
// result memory: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none

module cssq_result_mem #(
  parameter int DW = 14,
  parameter int AW = 5
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_a_addr,
  output logic      [DW-1:0] rd_a_data,
  input  wire logic [AW-1:0] rd_b_addr,
  output logic      [DW-1:0] rd_b_data
);

  localparam int DEPTH = 1 << AW;

  if (DW < 1 || AW < 1) begin : g_chk
    $error("cssq_result_mem: widths must be positive");
  end

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            a_r;
    logic [DW-1:0]            b_r;
  } cssq_mem_type;

  cssq_mem_type q_r;
  cssq_mem_type q_nxt;

  // reads see the old word on a same-address write; callers never rely on bypass
  always_comb begin
    q_nxt     = q_r;
    q_nxt.a_r = q_r.mem[rd_a_addr];
    q_nxt.b_r = q_r.mem[rd_b_addr];
    if (wr_en) begin
      q_nxt.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rd_a_data = q_r.a_r;
  assign rd_b_data = q_r.b_r;

endmodule

`default_nettype wire

// ---- verilog/HANDOVER_unused_placeholder_none.sv ----
// intentionally empty design unit list terminator
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- tb/cssq_sequencer_chk.sv ----
// port checker for the cell scan command sequencer
`timescale 1ns/1ps
`default_nettype none

module cssq_sequencer_chk #(
  parameter int T_CELL_FIRST = 340,
  parameter int T_LOAD       = 15320
) (
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  input wire logic                    dsy_clk,
  input wire cssq_pkg::cssq_role_type dev_role,
  input wire logic                    dsy_rx,
  input wire logic                    dsy_frame,
  input wire logic                    dsy_tx,
  input wire logic                    dsy_tx_oe,
  input wire logic                    scan_start,
  input wire logic                    cmd_end,
  input wire logic                    scan_busy,
  input wire logic                    scan_done,
  input wire logic [3:0]              adc_chan,
  input wire logic                    adc_hold,
  input wire logic                    adc_start,
  input wire logic                    adc_done
);
  // ==========================================
  // helper state
  logic [15:0] since_r;
  logic [3:0]  exp_r;

  // cycles since scan start, and the slot that must be converted next
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_r <= 16'h0000;
      exp_r   <= 4'hB;
    end else begin
      if (scan_start) since_r <= 16'h0001;
      else if (since_r != 16'hFFFF) since_r <= since_r + 16'h0001;
      if (scan_start) exp_r <= 4'hB;
      else if (adc_start && adc_chan == 4'h0) exp_r <= 4'hC;
      else if (adc_start && adc_chan > 4'hB) exp_r <= adc_chan + 4'h1;
      else if (adc_start) exp_r <= adc_chan - 4'h1;
    end
  end

  // ==========================================
  // sequences and assertions
  sequence s_conv_open;
    adc_hold && !adc_done;
  endsequence
  sequence s_scan_head;
    scan_start ##1 (scan_busy && !scan_start);
  endsequence

  a_solo_same_cycle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dev_role == cssq_pkg::CSSQ_SOLO |-> cmd_end == scan_start) else $error("solo end differs");
  a_master_end_late: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dev_role == cssq_pkg::CSSQ_MASTER && cmd_end |-> scan_busy) else $error("end before start");
  a_chain_no_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dev_role == cssq_pkg::CSSQ_CHAIN |-> !cmd_end) else $error("chained device ended command");
  a_start_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scan_start |-> s_scan_head) else $error("scan start not a pulse into busy");
  a_hold_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_conv_open |=> adc_hold) else $error("sample released before conversion done");
  a_chan_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adc_hold && !adc_start |-> $stable(adc_chan)) else $error("slot moved during hold");
  a_scan_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adc_start |-> adc_chan == exp_r) else $error("scan slot out of order");
  a_first_cell: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adc_start && adc_chan == 4'hB |-> since_r >= T_CELL_FIRST && since_r <= T_CELL_FIRST + 2)
    else $error("top cell sampled at wrong time");
  a_load_time: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scan_done |-> since_r >= T_LOAD && !adc_hold ##1 !scan_done) else $error("early load");
  a_chain_echo: assert property (@(posedge dsy_clk) disable iff (sys_rst)
    dev_role == cssq_pkg::CSSQ_CHAIN && dsy_frame |=> dsy_tx == $past(dsy_rx))
    else $error("chain data not passed on");
  a_chain_oe: assert property (@(posedge dsy_clk) disable iff (sys_rst)
    dev_role == cssq_pkg::CSSQ_CHAIN |=> dsy_tx_oe == $past(dsy_frame)) else $error("chain oe");
endmodule

bind cssq_sequencer cssq_sequencer_chk #(
  .T_CELL_FIRST(T_CELL_FIRST),
  .T_LOAD      (T_LOAD)
) i_chk (
  .ref_clk   (ref_clk),
  .sys_rst   (sys_rst),
  .dsy_clk   (dsy_clk),
  .dev_role  (dev_role),
  .dsy_rx    (dsy_rx),
  .dsy_frame (dsy_frame),
  .dsy_tx    (dsy_tx),
  .dsy_tx_oe (dsy_tx_oe),
  .scan_start(scan_start),
  .cmd_end   (cmd_end),
  .scan_busy (scan_busy),
  .scan_done (scan_done),
  .adc_chan  (adc_chan),
  .adc_hold  (adc_hold),
  .adc_start (adc_start),
  .adc_done  (adc_done)
);
`default_nettype wire

// ---- tb/cssq_host_model.sv ----
// host and upstream chain device model issuing command traffic
`timescale 1ns/1ps
`default_nettype none

module cssq_host_model (
  input  wire logic ref_clk,
  input  wire logic dsy_clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  output logic      dsy_rx,
  output logic      dsy_frame
);
  // idle: deselected; released data lines show the inverse of the last bit
  initial begin
    spi_sclk  = 1'b0;
    spi_cs_n  = 1'b1;
    spi_mosi  = 1'b0;
    dsy_rx    = 1'b1;
    dsy_frame = 1'b0;
  end

  // one spi phase is four reference cycles, so the synchroniser never misses an edge
  task automatic phase();
    repeat (4) @(posedge ref_clk);
  endtask

  // spi frame of n bytes, msb first: first byte b0, the rest b1
  task automatic spi_frame(input logic [7:0] b0, input logic [7:0] b1, input int n);
    logic [7:0] cur;
    // eight quiet chain clocks before chip select falls
    repeat (8) @(posedge dsy_clk);
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    for (int k = 0; k < 8 * n; k++) begin
      cur = (k < 8) ? b0 : b1;
      phase();
      spi_mosi <= cur[7 - k % 8];
      phase();
      spi_sclk <= 1'b1;
      phase();
      spi_sclk <= 1'b0;
    end
    phase();
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
  endtask

  // one chain byte from the device below, msb first, framed
  task automatic chain_frame(input logic [7:0] b);
    @(posedge dsy_clk);
    for (int k = 7; k >= 0; k--) begin
      dsy_frame <= 1'b1;
      dsy_rx    <= b[k];
      @(posedge dsy_clk);
    end
    dsy_frame <= 1'b0;
    dsy_rx    <= ~b[0];
  endtask
endmodule
`default_nettype wire

// ---- tb/cssq_sequencer_tb.sv ----
// self-checking bench for the cell scan command sequencer
`timescale 1ns/1ps
`default_nettype none

module cssq_sequencer_tb;
  logic ref_clk, sys_rst, dsy_clk, adc_done, rd_v, rd_v2;
  logic dsy_tx, dsy_tx_oe, scan_start, cmd_end, scan_busy, scan_done;
  logic fwd_overrun, adc_hold, adc_start;
  logic spi_sclk, spi_cs_n, spi_mosi, dsy_rx, dsy_frame;
  cssq_pkg::cssq_role_type dev_role;
  logic [3:0]  stack_size, rd_addr, adc_wait, adc_chan;
  logic [13:0] adc_data, cal_offset, rd_data;
  logic [13:0] sample [16];
  logic [16:0] tx_sr;
  logic [7:0]  tx_n;
  logic [15:0] q_chan[$];
  logic [15:0] q_rd[$];
  logic        q_end[$];
  int          seed = 95;
  int          checks = 0;
  int          miscompares = 0;

  cssq_sequencer i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .dsy_clk(dsy_clk), .dev_role(dev_role),
    .stack_size(stack_size), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .dsy_rx(dsy_rx), .dsy_frame(dsy_frame), .dsy_tx(dsy_tx),
    .dsy_tx_oe(dsy_tx_oe), .scan_start(scan_start), .cmd_end(cmd_end),
    .scan_busy(scan_busy), .scan_done(scan_done), .fwd_overrun(fwd_overrun),
    .adc_chan(adc_chan), .adc_hold(adc_hold), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .cal_offset(cal_offset),
    .rd_addr(rd_addr), .rd_data(rd_data));

  cssq_host_model i_host (.ref_clk(ref_clk), .dsy_clk(dsy_clk), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .dsy_rx(dsy_rx), .dsy_frame(dsy_frame));

  // ==========================================
  // clocks: 50 ns reference, 30 ns chain clock off phase
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    dsy_clk = 1'b0;
    #7;
    forever #15 dsy_clk = ~dsy_clk;
  end

  // ==========================================
  // compares and closing report
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // bounded wait for scan_done (0) or cmd_end (1); scan budget plus 10 percent
  task automatic wait_sig(input int sel);
    int n;
    n = 0;
    while (((sel == 0) ? scan_done : cmd_end) !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 17000) begin
        miscompares++;
        $display("ERROR t=%0t wait %0h timed out", $time, sel);
        wrap_up();
      end
    end
    @(posedge ref_clk);
  endtask

  // role is only changed while reset is held
  task automatic do_reset(input cssq_pkg::cssq_role_type role);
    sys_rst  <= 1'b1;
    dev_role <= role;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // notes one accepted scan: cmd_end level at its start, then the slot order
  task automatic note_scan(input logic end_exp);
    q_end.push_back(end_exp);
    for (int s = 11; s >= 0; s--) q_chan.push_back(16'(s));
    for (int s = 12; s < 16; s++) q_chan.push_back(16'(s));
  endtask

  // reads every slot back to back, noting converter value plus offset
  task automatic read_all();
    for (int s = 0; s < 16; s++) begin
      q_rd.push_back({2'h0, sample[s] + cal_offset});
      rd_addr <= 4'(s);
      rd_v    <= 1'b1;
      @(posedge ref_clk);
    end
    rd_v <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // ==========================================
  // converter: answers each conversion after 1 to 4 cycles
  always @(posedge ref_clk) begin
    adc_done <= !adc_start && adc_wait == 4'h1;
    if (adc_start) adc_wait <= 4'h1 + 4'($random(seed) & 3);
    else if (adc_wait != 4'h0) adc_wait <= adc_wait - 4'h1;
    if (adc_wait != 4'h0) adc_data <= sample[adc_chan];
  end

  // watcher: each result takes the oldest note of its kind
  always @(posedge ref_clk) begin
    rd_v2 <= rd_v;
    if (rd_v2) chk_val({2'h0, rd_data}, q_rd.size() ? q_rd.pop_front() : 16'hXXXX);
    if (adc_start) chk_val(16'(adc_chan), q_chan.size() ? q_chan.pop_front() : 16'hXXXX);
    if (scan_start) chk_bit(cmd_end, q_end.size() ? q_end.pop_front() : 1'bx);
  end

  // chain transmit collector, emptied at every reset
  always @(posedge dsy_clk) begin
    if (sys_rst) begin
      tx_sr <= 17'h00000;
      tx_n  <= 8'h00;
    end else if (dsy_tx_oe) begin
      tx_sr <= {tx_sr[15:0], dsy_tx};
      tx_n  <= tx_n + 8'h01;
    end
  end

  // ==========================================
  // main sequence: stand-alone, master of three, chained device
  initial begin
    sys_rst    = 1'b1;
    dev_role   = cssq_pkg::CSSQ_SOLO;
    stack_size = 4'h3;
    rd_addr    = 4'h0;
    rd_v       = 1'b0;
    rd_v2      = 1'b0;
    adc_done   = 1'b0;
    adc_wait   = 4'h0;
    adc_data   = 14'h0000;
    cal_offset = 14'($random(seed));
    for (int s = 0; s < 16; s++) sample[s] = 14'($random(seed));
    do_reset(cssq_pkg::CSSQ_SOLO);
    // wrong opcode, and the opcode as a second byte, start nothing
    i_host.spi_frame(8'h31, 8'h30, 1);
    i_host.spi_frame(8'h00, 8'h30, 2);
    note_scan(1'b1);
    i_host.spi_frame(8'h30, 8'h00, 1);
    // a repeat while busy is ignored
    i_host.spi_frame(8'h30, 8'h00, 1);
    wait_sig(0);
    read_all();
    do_reset(cssq_pkg::CSSQ_MASTER);
    note_scan(1'b0);
    i_host.spi_frame(8'h30, 8'h00, 1);
    wait_sig(1);
    chk_val({8'h00, tx_sr[16:9]}, 16'h0030);
    chk_val({7'h00, tx_sr[8:0]}, 16'h0000);
    chk_val({8'h00, tx_n}, 16'h0011);
    chk_bit(fwd_overrun, 1'b0);
    wait_sig(0);
    do_reset(cssq_pkg::CSSQ_CHAIN);
    // spi traffic and a wrong chain byte leave a chained device idle
    i_host.spi_frame(8'h30, 8'h00, 1);
    i_host.chain_frame(8'h31);
    note_scan(1'b0);
    i_host.chain_frame(8'h30);
    wait_sig(0);
    read_all();
    chk_val(16'(q_chan.size() + q_end.size()), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
